// File: src/pib_pkg.sv
// Constants, field layouts and helpers for the identification and config bank.
package pib_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Command codes of the bank.
  localparam logic [7:0] PIB_CMD_REVISION = 8'h9b;
  localparam logic [7:0] PIB_CMD_LOCATION = 8'h9c;
  localparam logic [7:0] PIB_CMD_DATE = 8'h9d;
  localparam logic [7:0] PIB_CMD_SERIAL = 8'h9e;
  localparam logic [7:0] PIB_CMD_SCRATCH = 8'hb0;
  localparam logic [7:0] PIB_CMD_FAULT_UNIT = 8'hc8;
  localparam logic [7:0] PIB_CMD_ADDR_POL = 8'hc9;

  ////////////////////////////////////////////////////////////////////////////
  // Register widths in bits and answer lengths in bytes.
  localparam int PIB_DATA_W = 160;
  localparam int PIB_TEXT12_W = 96;
  localparam int PIB_TEXT20_W = 160;
  localparam int PIB_SCRATCH_W = 128;
  localparam int PIB_UNIT_W = 8;
  localparam int PIB_CFG_W = 40;
  localparam int PIB_LEN_W = 5;
  localparam logic [4:0] PIB_LEN_TEXT12 = 5'h0c;
  localparam logic [4:0] PIB_LEN_TEXT20 = 5'h14;
  localparam logic [4:0] PIB_LEN_SCRATCH = 5'h10;
  localparam logic [4:0] PIB_LEN_UNIT = 5'h01;
  localparam logic [4:0] PIB_LEN_CFG = 5'h05;
  localparam logic [4:0] PIB_LEN_NONE = 5'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Retry time unit fields; class i sits at bit i * PIB_UNIT_SEL_W.
  localparam int PIB_CLASSES = 4;
  localparam int PIB_UNIT_SEL_W = 2;
  localparam int PIB_CODE_W = 3;
  localparam int PIB_MS_W = 16;
  localparam int PIB_CLS_TEMP = 0;
  localparam int PIB_CLS_IOUT = 1;
  localparam int PIB_CLS_VIN = 2;
  localparam int PIB_CLS_VOUT = 3;
  localparam int PIB_TEMP_UNIT_LSB = 0;
  localparam int PIB_IOUT_UNIT_LSB = 2;
  localparam int PIB_VIN_UNIT_LSB = 4;
  localparam int PIB_VOUT_UNIT_LSB = 6;
  localparam logic [15:0] PIB_UNIT_1MS = 16'h0001;
  localparam logic [15:0] PIB_UNIT_4MS = 16'h0004;
  localparam logic [15:0] PIB_UNIT_16MS = 16'h0010;
  localparam logic [15:0] PIB_UNIT_256MS = 16'h0100;

  ////////////////////////////////////////////////////////////////////////////
  // Address and polarity fields of the configuration register.
  localparam int PIB_BASE_LSB = 24;
  localparam int PIB_BASE_W = 8;
  localparam int PIB_OFS_LSB = 17;
  localparam int PIB_OFS_W = 7;
  localparam int PIB_RES_EN_BIT = 16;
  localparam int PIB_CTRL_POL_BIT = 32;
  localparam int PIB_PG_POL_BIT = 39;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset and factory text; the text values are arbitrary.
  localparam logic [95:0] PIB_TEXT12_RST = 96'h0;
  localparam logic [127:0] PIB_SCRATCH_RST = 128'h0;
  localparam logic [7:0] PIB_UNIT_RST = 8'h00;
  localparam logic [39:0] PIB_CFG_RST = 40'h00_0000_0000;
  localparam logic [95:0] PIB_DATE_DEFAULT = 96'h303030303030303030303030;
  localparam logic [159:0] PIB_SERIAL_DEFAULT =
    160'h0000000000000030303030303030303030303031;

  // Masks that keep the meaningful low bytes of an answer.
  localparam logic [159:0] PIB_MASK_TEXT12 = {64'h0, {96{1'b1}}};
  localparam logic [159:0] PIB_MASK_SCRATCH = {32'h0, {128{1'b1}}};

  // Answer state, one-hot.
  typedef enum logic [1:0] {
    PIB_IDLE = 2'b01,
    PIB_ANSWER = 2'b10
  } pib_state_t;

  // Milliseconds per retry time unit for a two-bit selection.
  function automatic logic [15:0] pib_unit_ms(input logic [1:0] sel);
    logic [15:0] ms;
    ms = PIB_UNIT_1MS;
    case (sel)
      2'h0: ms = PIB_UNIT_1MS;
      2'h1: ms = PIB_UNIT_4MS;
      2'h2: ms = PIB_UNIT_16MS;
      default: ms = PIB_UNIT_256MS;
    endcase
    return ms;
  endfunction

endpackage

// File: src/pib_retry_time.sv
// Retry time decoder for one fault class: unit size and total delay in ms.
`timescale 1ns/10ps
`default_nettype none

module pib_retry_time
  import pib_pkg::*;
(
  input wire logic [1:0] unit_sel,
  input wire logic [2:0] delay_code,
  output logic [15:0] unit_ms,
  output logic [15:0] delay_ms
);

  ////////////////////////////////////////////////////////////////////////////
  // The unit selection picks 1, 4, 16 or 256 ms; the delay code counts
  // 1, 2, 4 up to 128 units, so the total is the unit shifted by the code.
  // The largest total, 256 ms times 128, still fits sixteen bits.
  assign unit_ms = pib_unit_ms(unit_sel); // R6 R7 R8 R9
  assign delay_ms = unit_ms << delay_code; // R18

endmodule

`default_nettype wire

// File: src/pib_regs.sv
// Identification, scratch, retry time unit and address/polarity bank.
`timescale 1ns/10ps
`default_nettype none

// How it works
// R1: Revision text, twelve characters, read and write.
// R2: Location text, twelve characters, read and write.
// R3: Build date text returned on read only.
// R4: Serial text, thirteen characters, twenty byte field.
// R5: Sixteen scratch bytes echo the last write.
// R6: Input voltage unit bits 5:4 pick 1/4/16/256ms.
// R7: Output voltage unit from bits 7:6.
// R8: Output current unit from bits 3:2.
// R9: Temperature unit from bits 1:0.
// R10: Bits 31:24 hold base; offset added to it.
// R11: Bits 23:17 programmed offset when resistor disabled.
// R12: Bit 16 selects resistor offset over programmed.
// R13: Bit 39 sets power good output polarity.
// R14: Bit 32 sets remote control input polarity.
// R15: Address is base plus offset, or strap pins.
// R16: Host keeps fault, good, enable pins distinct.
// R17: Host keeps the two bus addresses different.
// R18: Retry delay is 2^code units of chosen size.
module pib_regs
  import pib_pkg::*;
#(
  parameter logic [95:0] BUILD_DATE = PIB_DATE_DEFAULT,
  parameter logic [159:0] UNIT_SERIAL = PIB_SERIAL_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [159:0] cmd_wdata,
  output logic rsp_valid,
  output logic [159:0] rsp_data,
  output logic [4:0] rsp_len,
  output logic rsp_unsupported,
  input wire logic [11:0] retry_delay_code,
  output logic [63:0] retry_unit_ms,
  output logic [63:0] retry_delay_ms,
  input wire logic [6:0] resistor_offset,
  input wire logic use_strap_pins,
  input wire logic addr_strap_pin_a,
  input wire logic addr_strap_pin_b,
  output logic [7:0] pmbus_addr,
  input wire logic power_good_int,
  output logic power_good_pin,
  input wire logic remote_ctrl_pin,
  output logic remote_on
);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////////////////////
  // Storage and answer state.
  pib_state_t state_q;
  pib_state_t state_d;
  logic [95:0] revision_q;
  logic [95:0] location_q;
  logic [127:0] scratch_q;
  logic [7:0] units_q;
  logic [39:0] cfg_q;
  logic [159:0] rsp_data_q;
  logic [4:0] rsp_len_q;
  logic rsp_unsup_q;

  ////////////////////////////////////////////////////////////////////////////
  // Command acceptance: one command at a time, answered the next cycle.
  logic take;
  logic take_wr;
  assign cmd_ready = (state_q == PIB_IDLE);
  assign take = cmd_valid && cmd_ready;
  assign take_wr = take && cmd_write;
  assign state_d = take ? PIB_ANSWER : PIB_IDLE;
  assign rsp_valid = (state_q == PIB_ANSWER);

  // Write strobes per writable command.
  logic wr_revision;
  logic wr_location;
  logic wr_scratch;
  logic wr_units;
  logic wr_cfg;
  assign wr_revision = take_wr && (cmd_code == PIB_CMD_REVISION);
  assign wr_location = take_wr && (cmd_code == PIB_CMD_LOCATION);
  assign wr_scratch = take_wr && (cmd_code == PIB_CMD_SCRATCH);
  assign wr_units = take_wr && (cmd_code == PIB_CMD_FAULT_UNIT);
  assign wr_cfg = take_wr && (cmd_code == PIB_CMD_ADDR_POL);

  // A write to a read-only or unknown code is refused and stores nothing.
  logic wr_known;
  assign wr_known = wr_revision || wr_location || wr_scratch || wr_units ||
    wr_cfg;

  ////////////////////////////////////////////////////////////////////////////
  // Read selection: contents padded with zeros above, plus the byte count.
  logic [159:0] rd_data;
  logic [4:0] rd_len;
  logic rd_known;
  always_comb begin
    rd_data = 160'h0;
    rd_len = PIB_LEN_NONE;
    rd_known = 1'b1;
    case (cmd_code)
      PIB_CMD_REVISION: begin
        rd_data = {64'h0, revision_q}; // R1
        rd_len = PIB_LEN_TEXT12;
      end
      PIB_CMD_LOCATION: begin
        rd_data = {64'h0, location_q}; // R2
        rd_len = PIB_LEN_TEXT12;
      end
      PIB_CMD_DATE: begin
        rd_data = {64'h0, BUILD_DATE}; // R3
        rd_len = PIB_LEN_TEXT12;
      end
      PIB_CMD_SERIAL: begin
        rd_data = UNIT_SERIAL; // R4
        rd_len = PIB_LEN_TEXT20;
      end
      PIB_CMD_SCRATCH: begin
        rd_data = {32'h0, scratch_q}; // R5
        rd_len = PIB_LEN_SCRATCH;
      end
      PIB_CMD_FAULT_UNIT: begin
        rd_data = {152'h0, units_q};
        rd_len = PIB_LEN_UNIT;
      end
      PIB_CMD_ADDR_POL: begin
        rd_data = {120'h0, cfg_q};
        rd_len = PIB_LEN_CFG;
      end
      default: begin
        rd_known = 1'b0;
      end
    endcase
  end

  // Answer contents: a write answers with no data, a read with the value.
  logic [159:0] ans_data;
  logic [4:0] ans_len;
  logic ans_unsup;
  assign ans_data = cmd_write ? 160'h0 : rd_data;
  assign ans_len = cmd_write ? PIB_LEN_NONE : rd_len;
  assign ans_unsup = cmd_write ? !wr_known : !rd_known;

  ////////////////////////////////////////////////////////////////////////////
  // Answer state and registered answer.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_q <= PIB_IDLE;
      rsp_data_q <= 160'h0;
      rsp_len_q <= PIB_LEN_NONE;
      rsp_unsup_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (take) begin
        rsp_data_q <= ans_data;
        rsp_len_q <= ans_len;
        rsp_unsup_q <= ans_unsup;
      end
    end
  end

  assign rsp_data = rsp_data_q;
  assign rsp_len = rsp_len_q;
  assign rsp_unsupported = rsp_unsup_q;

  ////////////////////////////////////////////////////////////////////////////
  // Writable text and scratch storage; a write keeps the low bits.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      revision_q <= PIB_TEXT12_RST;
      location_q <= PIB_TEXT12_RST;
      scratch_q <= PIB_SCRATCH_RST;
    end else begin
      if (wr_revision) begin
        revision_q <= cmd_wdata[95:0]; // R1
      end
      if (wr_location) begin
        location_q <= cmd_wdata[95:0]; // R2
      end
      if (wr_scratch) begin
        scratch_q <= cmd_wdata[127:0]; // R5
      end
    end
  end

  // Retry time unit and address/polarity configuration.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      units_q <= PIB_UNIT_RST;
      cfg_q <= PIB_CFG_RST;
    end else begin
      if (wr_units) begin
        units_q <= cmd_wdata[7:0];
      end
      if (wr_cfg) begin
        cfg_q <= cmd_wdata[39:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Retry timing per fault class: temperature, current, input, output.
  logic [63:0] unit_ms_w;
  logic [63:0] delay_ms_w;
  for (genvar i = 0; i < PIB_CLASSES; i++) begin : g_class
    pib_retry_time u_retry (
      .unit_sel(units_q[i*PIB_UNIT_SEL_W +: PIB_UNIT_SEL_W]), // R6 R7 R8 R9
      .delay_code(retry_delay_code[i*PIB_CODE_W +: PIB_CODE_W]),
      .unit_ms(unit_ms_w[i*PIB_MS_W +: PIB_MS_W]),
      .delay_ms(delay_ms_w[i*PIB_MS_W +: PIB_MS_W])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address derivation: base plus resistor or programmed offset, or strap.
  logic [7:0] base_addr;
  logic [6:0] prog_offset;
  logic res_en;
  logic [6:0] sel_offset;
  logic [7:0] offset_addr;
  logic [7:0] strap_addr;
  logic [7:0] addr_d;
  assign base_addr = cfg_q[PIB_BASE_LSB +: PIB_BASE_W]; // R10
  assign prog_offset = cfg_q[PIB_OFS_LSB +: PIB_OFS_W];
  assign res_en = cfg_q[PIB_RES_EN_BIT];
  assign sel_offset = res_en ? resistor_offset : prog_offset; // R11 R12
  assign offset_addr = base_addr + {1'b0, sel_offset}; // R10
  assign strap_addr = base_addr +
    {6'h00, addr_strap_pin_b, addr_strap_pin_a};
  assign addr_d = use_strap_pins ? strap_addr : offset_addr; // R15

  // Polarity: a set bit means active high, a clear bit active low.
  logic pg_pol;
  logic ctrl_pol;
  logic pg_d;
  logic on_d;
  assign pg_pol = cfg_q[PIB_PG_POL_BIT];
  assign ctrl_pol = cfg_q[PIB_CTRL_POL_BIT];
  assign pg_d = pg_pol ? power_good_int : !power_good_int; // R13
  assign on_d = ctrl_pol ? remote_ctrl_pin : !remote_ctrl_pin; // R14

  ////////////////////////////////////////////////////////////////////////////
  // Registered data outputs. After reset the power good pin reads as not
  // good under the reset polarity, which is active low.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      retry_unit_ms <= 64'h0;
      retry_delay_ms <= 64'h0;
      pmbus_addr <= 8'h00;
      power_good_pin <= 1'b1;
      remote_on <= 1'b0;
    end else begin
      retry_unit_ms <= unit_ms_w;
      retry_delay_ms <= delay_ms_w;
      pmbus_addr <= addr_d;
      power_good_pin <= pg_d;
      remote_on <= on_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the stored text: a write read back two cycles later echoes.
  sequence s_wr(logic [7:0] c);
    take && cmd_write && (cmd_code == c);
  endsequence

  sequence s_rd(logic [7:0] c);
    take && !cmd_write && (cmd_code == c);
  endsequence

  property p_echo(logic [7:0] c, logic [159:0] m);
    s_wr(c) ##2 s_rd(c) |=>
      rsp_valid && ((rsp_data & m) == ($past(cmd_wdata, 3) & m));
  endproperty

  a_revision_echo: assert property ( // R1
    p_echo(PIB_CMD_REVISION, PIB_MASK_TEXT12))
    else $error("revision text did not echo the write");

  a_location_echo: assert property ( // R2
    p_echo(PIB_CMD_LOCATION, PIB_MASK_TEXT12))
    else $error("location text did not echo the write");

  a_scratch_echo: assert property ( // R5
    p_echo(PIB_CMD_SCRATCH, PIB_MASK_SCRATCH))
    else $error("scratch bytes did not echo the write");

  // Read-only texts answer their fixed value and refuse writes.
  a_date_read: assert property ( // R3
    s_rd(PIB_CMD_DATE) |=> rsp_valid && !rsp_unsupported &&
      (rsp_data == {64'h0, BUILD_DATE}) && (rsp_len == PIB_LEN_TEXT12))
    else $error("build date answer wrong");

  a_date_refused: assert property ( // R3
    s_wr(PIB_CMD_DATE) |=> rsp_valid && rsp_unsupported &&
      (rsp_len == PIB_LEN_NONE))
    else $error("write to build date was not refused");

  a_serial_read: assert property ( // R4
    s_rd(PIB_CMD_SERIAL) |=> rsp_valid && !rsp_unsupported &&
      (rsp_data == UNIT_SERIAL) && (rsp_len == PIB_LEN_TEXT20))
    else $error("serial answer wrong");

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the retry units: two cycles after a write the unit shows.
  a_vin_unit: assert property ( // R6
    s_wr(PIB_CMD_FAULT_UNIT) |=> ##1
      retry_unit_ms[PIB_CLS_VIN*PIB_MS_W +: PIB_MS_W] ==
      pib_unit_ms($past(cmd_wdata[PIB_VIN_UNIT_LSB +: 2], 2)))
    else $error("input voltage retry unit wrong");

  a_vout_unit: assert property ( // R7
    s_wr(PIB_CMD_FAULT_UNIT) |=> ##1
      retry_unit_ms[PIB_CLS_VOUT*PIB_MS_W +: PIB_MS_W] ==
      pib_unit_ms($past(cmd_wdata[PIB_VOUT_UNIT_LSB +: 2], 2)))
    else $error("output voltage retry unit wrong");

  a_iout_unit: assert property ( // R8
    s_wr(PIB_CMD_FAULT_UNIT) |=> ##1
      retry_unit_ms[PIB_CLS_IOUT*PIB_MS_W +: PIB_MS_W] ==
      pib_unit_ms($past(cmd_wdata[PIB_IOUT_UNIT_LSB +: 2], 2)))
    else $error("output current retry unit wrong");

  a_temp_unit: assert property ( // R9
    s_wr(PIB_CMD_FAULT_UNIT) |=> ##1
      retry_unit_ms[PIB_CLS_TEMP*PIB_MS_W +: PIB_MS_W] ==
      pib_unit_ms($past(cmd_wdata[PIB_TEMP_UNIT_LSB +: 2], 2)))
    else $error("temperature retry unit wrong");

  // The total delay of the output current class is its unit times two to the code.
  a_delay_scale: assert property ( // R18
    ##1 retry_delay_ms[PIB_CLS_IOUT*PIB_MS_W +: PIB_MS_W] ==
      (retry_unit_ms[PIB_CLS_IOUT*PIB_MS_W +: PIB_MS_W] <<
       $past(retry_delay_code[PIB_CLS_IOUT*PIB_CODE_W +: PIB_CODE_W])))
    else $error("retry delay does not scale with code");

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the address and the polarity outputs.
  a_prog_offset: assert property ( // R10 R11
    (!use_strap_pins && !res_en) |=>
      pmbus_addr == 8'($past(base_addr) + {1'b0, $past(prog_offset)}))
    else $error("programmed offset address wrong");

  a_res_offset: assert property ( // R12
    (!use_strap_pins && res_en) |=>
      pmbus_addr == 8'($past(base_addr) + {1'b0, $past(resistor_offset)}))
    else $error("resistor offset address wrong");

  a_strap_addr: assert property ( // R15
    use_strap_pins |=> pmbus_addr == 8'($past(base_addr) +
      {6'h00, $past(addr_strap_pin_b), $past(addr_strap_pin_a)}))
    else $error("strap address wrong");

  a_pg_polarity: assert property ( // R13
    ##1 power_good_pin == ($past(power_good_int) ~^ $past(pg_pol)))
    else $error("power good polarity wrong");

  a_ctrl_polarity: assert property ( // R14
    ##1 remote_on == ($past(remote_ctrl_pin) ~^ $past(ctrl_pol)))
    else $error("remote control polarity wrong");

endmodule

`default_nettype wire

// File: bench/pib_host_model.sv
// Host model that issues whole register commands to the bank.
`timescale 1ns/10ps
`default_nettype none

module pib_host_model (
  input wire logic ref_clk,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic [159:0] rsp_data,
  input wire logic [4:0] rsp_len,
  input wire logic rsp_unsupported,
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [159:0] cmd_wdata
);
  // Request lines are quiet from time zero.
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = '0;
  end

  //////////////////////////////////////////////////////////////////////////
  // One command; the request holds until taken, then the lines are inverted
  // so a stale value is never mistaken for a fresh one. The caller never
  // puts two pin functions on one pin and sets only one bus address.
  task automatic xfer(input logic wr, input logic [7:0] code,
    input logic [159:0] wd, output logic [159:0] data,
    output logic [4:0] len, output logic unsup, output logic ok);
    int n;
    n = 0;
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_code <= code;
    cmd_wdata <= wd;
    @(negedge ref_clk);
    while (cmd_ready !== 1'b1 && n < 16) begin
      @(negedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    cmd_write <= ~wr;
    cmd_code <= ~code;
    cmd_wdata <= ~wd;
    @(negedge ref_clk);
    ok = (n < 16) && (rsp_valid === 1'b1) && (cmd_ready === 1'b0);
    data = rsp_data;
    len = rsp_len;
    unsup = rsp_unsupported;
  endtask
endmodule

`default_nettype wire

// File: bench/tb.sv
// Self-checking testbench for the identification and configuration bank.
`timescale 1ns/10ps
`default_nettype none

module tb
  import pib_pkg::*;
;
  localparam logic [95:0] DATE = 96'h323032343130323000000000;
  localparam logic [159:0] SER = 160'h0000000000000041424344454647484950515253;
  logic ref_clk, srst, cmd_valid, cmd_ready, cmd_write;
  logic rsp_valid, rsp_unsupported, use_strap_pins;
  logic addr_strap_pin_a, addr_strap_pin_b, power_good_int;
  logic power_good_pin, remote_ctrl_pin, remote_on, r_unsup;
  logic [7:0] cmd_code, pmbus_addr;
  logic [159:0] cmd_wdata, rsp_data, r_data;
  logic [4:0] rsp_len, r_len;
  logic [11:0] retry_delay_code;
  logic [63:0] retry_unit_ms, retry_delay_ms;
  logic [6:0] resistor_offset;
  int fails = 0;
  int check_count = 0;

  pib_regs #(.BUILD_DATE(DATE), .UNIT_SERIAL(SER)) dut (.ref_clk(ref_clk),
    .srst(srst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_len(rsp_len),
    .rsp_unsupported(rsp_unsupported), .retry_delay_code(retry_delay_code),
    .retry_unit_ms(retry_unit_ms), .retry_delay_ms(retry_delay_ms),
    .resistor_offset(resistor_offset), .use_strap_pins(use_strap_pins),
    .addr_strap_pin_a(addr_strap_pin_a), .addr_strap_pin_b(addr_strap_pin_b),
    .pmbus_addr(pmbus_addr), .power_good_int(power_good_int),
    .power_good_pin(power_good_pin), .remote_ctrl_pin(remote_ctrl_pin),
    .remote_on(remote_on));

  pib_host_model host (.ref_clk(ref_clk), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_len(rsp_len),
    .rsp_unsupported(rsp_unsupported), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));

  // Free-running 250 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  //////////////////////////////////////////////////////////////////////////
  // Verdict, comparison and command helpers.
  task automatic final_report();
    if (fails == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string what);
    check_count++;
    if (ok !== 1'b1) begin
      fails++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask

  task automatic cmd(input logic wr, input logic [7:0] code,
    input logic [159:0] wd);
    logic ok;
    host.xfer(wr, code, wd, r_data, r_len, r_unsup, ok);
    if (ok !== 1'b1) begin
      fails++;
      $display("[FAIL] %0t no answer", $time);
      final_report();
    end
  endtask

  // Milliseconds per unit for a two-bit selection.
  function automatic logic [15:0] ums(input int s);
    return (s == 0) ? 16'h0001 : (s == 1) ? 16'h0004 :
      (s == 2) ? 16'h0010 : 16'h0100;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic sc_reset();
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk(cmd_ready === 1'b1 && pmbus_addr === 8'h00, "idle after reset");
    chk(retry_unit_ms === {4{16'h0001}}, "unit after reset");
    chk(power_good_pin === 1'b1 && remote_on === 1'b0, "pins after reset");
    cmd(1'b0, PIB_CMD_SCRATCH, '0);
    chk(r_data === '0 && r_len === 5'h10, "scratch reset");
  endtask

  // Each text and scratch store is written and read back at once, then all are read again.
  task automatic sc_rw();
    logic [7:0] codes [3];
    int w [3];
    codes = '{PIB_CMD_REVISION, PIB_CMD_LOCATION, PIB_CMD_SCRATCH};
    w = '{96, 96, 128};
    for (int i = 0; i < 3; i++) begin
      cmd(1'b1, codes[i], {5{32'h5a3c0f00 + 32'(i)}});
      chk(r_data === '0 && r_len === 5'h00 && r_unsup === 1'b0,
        "write answer");
      cmd(1'b0, codes[i], '0);
      chk(r_data[31:0] === (32'h5a3c0f00 + 32'(i)), "echo");
    end
    for (int i = 0; i < 3; i++) begin
      cmd(1'b0, codes[i], '0);
      chk(r_data === ({5{32'h5a3c0f00 + 32'(i)}} &
        ({160{1'b1}} >> (160 - w[i]))), "readback");
      chk(r_len === 5'(w[i] / 8), "read length");
    end
  endtask

  // Fixed text reads; writes to them and unknown codes are refused.
  task automatic sc_ro();
    cmd(1'b0, PIB_CMD_DATE, '0);
    chk(r_data === {64'h0, DATE} && r_len === 5'h0c, "date");
    cmd(1'b1, PIB_CMD_DATE, '1);
    chk(r_unsup === 1'b1, "date write refused");
    cmd(1'b1, PIB_CMD_SERIAL, '1);
    chk(r_unsup === 1'b1, "serial write refused");
    cmd(1'b0, PIB_CMD_SERIAL, '0);
    chk(r_data === SER && r_len === 5'h14, "serial");
    cmd(1'b0, PIB_CMD_DATE, '0);
    chk(r_data === {64'h0, DATE} && r_unsup === 1'b0, "date kept");
    cmd(1'b0, 8'h99, '0);
    chk(r_unsup === 1'b1, "unknown code");
    cmd(1'b1, 8'h99, '1);
    chk(r_unsup === 1'b1 && r_len === 5'h00, "unknown write");
  endtask

  // Every unit selection in every class, with four of the eight delay codes per class.
  task automatic sc_units();
    logic [7:0] sel;
    logic [11:0] code;
    for (int k = 0; k < 4; k++) begin
      for (int c = 0; c < 4; c++) begin
        sel[c*2 +: 2] = 2'((k + c) % 4);
        code[c*3 +: 3] = 3'((2 * k + c) % 8);
      end
      @(posedge ref_clk);
      retry_delay_code <= code;
      cmd(1'b1, PIB_CMD_FAULT_UNIT, {152'h0, sel});
      @(posedge ref_clk);
      @(negedge ref_clk);
      for (int c = 0; c < 4; c++) begin
        chk(retry_unit_ms[c*16 +: 16] === ums((k + c) % 4),
          "unit");
        chk(retry_delay_ms[c*16 +: 16] ===
          (ums((k + c) % 4) << ((2 * k + c) % 8)), "delay");
      end
      cmd(1'b0, PIB_CMD_FAULT_UNIT, '0);
      chk(r_data === {152'h0, sel} && r_len === 5'h01,
        "unit readback");
    end
  endtask

  // Address sources and both polarities of both pins.
  task automatic sc_addr();
    logic [39:0] cfg;
    logic [7:0] exp;
    for (int i = 0; i < 4; i++) begin
      // Only one bus address is set, so no two can clash.
      cfg = {i[1], 6'h00, i[0], 8'hf0, 7'h15, i[0], 16'h0000};
      exp = (i == 3) ? 8'hf1 : (i[0] ? 8'h12 : 8'h05);
      @(posedge ref_clk);
      use_strap_pins <= (i == 3);
      resistor_offset <= 7'h22;
      addr_strap_pin_a <= 1'b1;
      addr_strap_pin_b <= 1'b0;
      cmd(1'b1, PIB_CMD_ADDR_POL, {120'h0, cfg});
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk(pmbus_addr === exp, "address");
      for (int j = 0; j < 2; j++) begin
        @(posedge ref_clk);
        power_good_int <= j[0];
        remote_ctrl_pin <= j[0];
        @(posedge ref_clk);
        @(negedge ref_clk);
        chk(power_good_pin === (i[1] ? j[0] : ~j[0]), "good pin");
        chk(remote_on === (i[0] ? j[0] : ~j[0]), "control pin");
      end
      cmd(1'b0, PIB_CMD_ADDR_POL, '0);
      chk(r_data === {120'h0, cfg} && r_len === 5'h05,
        "config readback");
    end
  endtask

  // Reset, then the scenarios in turn.
  initial begin
    srst = 1'b1;
    retry_delay_code = 12'h000;
    resistor_offset = 7'h00;
    use_strap_pins = 1'b0;
    addr_strap_pin_a = 1'b0;
    addr_strap_pin_b = 1'b0;
    power_good_int = 1'b0;
    remote_ctrl_pin = 1'b1;
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    sc_reset();
    sc_rw();
    sc_ro();
    sc_units();
    sc_addr();
    final_report();
  end
endmodule

`default_nettype wire
